// ### src/serial_regs.sv
// Purpose: Interface error and interface control registers on Wishbone.
// Assumes: Layer event inputs are one-cycle pulses on CLK; PHY_READY is
//          asynchronous and is synchronised here.
// Notes: Error flags live in error_flags; this module owns the bus,
//        control register and event gathering.
//        The ready flops reset low, so a ready level already high when
//        reset ends is reported once as a ready change.
//
// What this block does
// - Error register keeps every flag until cleared.
// - Writing ones clears those flags only.
// - Reset clears every error flag.
// - Persistent communication error sets its flag.
// - Adapter internal fault sets internal flag.
// - Recovered integrity error sets its flag.
// - Link lost then regained sets flag.
// - Protocol violation sets protocol flag.
// - Unrecovered transient integrity error sets flag.
// - Reserved bits of both registers read zero.
// - 10b/8b decode error sets decode flag.
// - CRC and disparity errors set flags.
// - Unknown frame type with good CRC flags.
// - Phy internal error sets its flag.
// - Ready signal toggle sets change flag.
// - Negative handshake sets handshake flag.
// - Link or transport bad transition flags.
// - Wake signal detection sets wake flag.
// - Control reads last write; writes act.
// - Detect field: none, hold reset, offline.
// - Speed field may cap at generation one.
// - Power field blocks partial and slumber.
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module serial_regs
    import scr_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ADR_W-1:0] WB_ADR_I,
    input wire logic [SEL_W-1:0] WB_SEL_I,
    input wire logic [DATA_W-1:0] WB_DAT_I,
    output logic [DATA_W-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Phy events
    input wire logic PHY_READY,
    input wire logic PHY_INT_ERR,
    input wire logic COMWAKE_SEEN,
    input wire logic DECODE_ERR,
    input wire logic DISPARITY_ERR,
    // Link events
    input wire logic CRC_ERR,
    input wire logic HANDSHAKE_ERR,
    input wire logic LINK_SEQ_ERR,
    // Transport events
    input wire logic UNKNOWN_FIS,
    input wire logic TRANSPORT_ERR,
    input wire logic PROTOCOL_ERR,
    // Error class events
    input wire logic PERSIST_ERR,
    input wire logic INTERNAL_ERR,
    input wire logic RECOV_INTEGRITY,
    input wire logic TRANSIENT_ERR,
    // Control outputs
    output logic PHY_RESET_HOLD,
    output logic PHY_OFFLINE,
    output logic SPEED_GEN1_ONLY,
    output logic PARTIAL_BLOCK,
    output logic SLUMBER_BLOCK,
    output logic CTRL_UPDATE
);

    // ============================================================
    // State
    // Every flop of this module sits in this one packed word.
    typedef struct packed {
        logic rdy_meta;
        logic rdy_sync;
        logic rdy_prev;
        logic link_lost;
        logic ack;
        logic [DATA_W-1:0] rdat;
        logic [CTRL_W-1:0] ctrl;
        logic reset_hold;
        logic offline;
        logic gen1_only;
        logic partial_blk;
        logic slumber_blk;
        logic ctrl_upd;
    } state_t;

    state_t state_reg;
    state_t state_next;

    err_evt_if evt_bus ();

    logic [DATA_W-1:0] lane_mask;
    logic [IDX_W-1:0] reg_idx;
    logic bus_req;
    logic wr_commit;
    logic rdy_rise;
    logic rdy_fall;
    logic [DATA_W-1:0] events;
    logic [DATA_W-1:0] ctrl_word;
    logic [DATA_W-1:0] ctrl_merged;
    logic [FIELD_W-1:0] det_f;
    logic [FIELD_W-1:0] spd_f;
    logic [FIELD_W-1:0] ipm_f;

    // ============================================================
    // Sticky flag store
    // Flags live in their own module so that the set-over-clear choice
    // has a single home.
    error_flags flag_store
    (
        .clk(CLK),
        .rst_b(RST_B),
        .evt(evt_bus.sink)
    );

    // ============================================================
    // Byte lane expansion
    // Each select bit widens to cover its own byte of data.
    genvar lane;
    generate
        for (lane = 0; lane < SEL_W; lane = lane + 1)
        begin : g_lane
            assign lane_mask[lane*BYTE_W +: BYTE_W] = {BYTE_W{WB_SEL_I[lane]}};
        end
    endgenerate

    // ============================================================
    // Bus decode
    // A write lands only on the edge where ack is seen, so a held request
    // writes once per ack, on every second edge.
    // Unmapped indexes are still acked, so software probing the reserved
    // space never hangs the bus; their reads return zero.
    assign reg_idx = WB_ADR_I[ADR_W-1:IDX_LSB];
    assign bus_req = WB_CYC_I && WB_STB_I;
    assign wr_commit = bus_req && WB_WE_I && state_reg.ack;

    // ============================================================
    // Ready edges
    // Edges come from the synchronised level only, never from the pin.
    assign rdy_rise = state_reg.rdy_sync && !state_reg.rdy_prev;
    assign rdy_fall = !state_reg.rdy_sync && state_reg.rdy_prev;

    // ============================================================
    // Event gathering
    // Each event pin is high for one cycle per event; a held level just
    // keeps setting its flag, which is harmless for a sticky store.
    always_comb
    begin
        events = ZERO_WORD;
        events[ERR_PERSIST] = PERSIST_ERR;
        events[ERR_INTERNAL] = INTERNAL_ERR;
        events[ERR_RECOV_INTEG] = RECOV_INTEGRITY;
        events[ERR_RECOV_COMM] = rdy_rise && state_reg.link_lost;
        events[ERR_PROTOCOL] = PROTOCOL_ERR;
        events[ERR_TRANSIENT] = TRANSIENT_ERR;
        events[DIAGNOSTIC_FIELD_DECODE] = DECODE_ERR;
        events[DIAGNOSTIC_FIELD_CRC] = CRC_ERR;
        events[DIAGNOSTIC_FIELD_DISPARITY] = DISPARITY_ERR;
        events[DIAGNOSTIC_FIELD_UNKNOWN_FIS] = UNKNOWN_FIS;
        events[DIAGNOSTIC_FIELD_PHY_INT] = PHY_INT_ERR;
        events[DIAGNOSTIC_FIELD_READY_CHG] = rdy_rise || rdy_fall;
        events[DIAGNOSTIC_FIELD_HANDSHAKE] = HANDSHAKE_ERR;
        events[DIAGNOSTIC_FIELD_LINK_SEQ] = LINK_SEQ_ERR;
        events[DIAGNOSTIC_FIELD_TRANSPORT] = TRANSPORT_ERR;
        events[DIAGNOSTIC_FIELD_WAKE] = COMWAKE_SEEN;
    end

    assign evt_bus.set_vec = events;
    assign evt_bus.clr_mask = (wr_commit && reg_idx == ERR_IDX) ?
        (WB_DAT_I & lane_mask) : ZERO_WORD;

    // ============================================================
    // Control write merge
    // Lanes left out of a write keep their stored bits, so one field can
    // change without a read first.
    assign ctrl_word = {{(DATA_W-CTRL_W){1'b0}}, state_reg.ctrl};
    assign ctrl_merged = (ctrl_word & ~lane_mask) | (WB_DAT_I & lane_mask);

    // ============================================================
    // Next state
    always_comb
    begin
        state_next = state_reg;
        det_f = state_reg.ctrl[DET_LSB +: FIELD_W];
        spd_f = state_reg.ctrl[SPD_LSB +: FIELD_W];
        ipm_f = state_reg.ctrl[IPM_LSB +: FIELD_W];

        // Ready level crosses in on two flops before anything reads it.
        state_next.rdy_meta = PHY_READY;
        state_next.rdy_sync = state_reg.rdy_meta;
        state_next.rdy_prev = state_reg.rdy_sync;

        // A loss that never ends shows only as a ready change.
        // remember a loss until ready returns
        if (rdy_fall)
        begin
            state_next.link_lost = 1'b1;
        end
        else if (rdy_rise)
        begin
            state_next.link_lost = 1'b0;
        end

        // Ack is registered and drops the cycle after it is given.
        // A strobe held past its ack is taken again on the next edge.
        state_next.ack = bus_req && !state_reg.ack;
        state_next.rdat = ZERO_WORD;
        if (bus_req && !state_reg.ack && !WB_WE_I)
        begin
            case (reg_idx)
                ERR_IDX:
                begin
                    state_next.rdat = evt_bus.flags & ERR_VALID_MASK;
                end
                CTRL_IDX:
                begin
                    state_next.rdat = ctrl_word;
                end
                default:
                begin
                    state_next.rdat = ZERO_WORD;
                end
            endcase
        end

        state_next.ctrl_upd = 1'b0;
        if (wr_commit && reg_idx == CTRL_IDX)
        begin
            state_next.ctrl = ctrl_merged[CTRL_W-1:0];
            state_next.ctrl_upd = 1'b1;
            det_f = ctrl_merged[DET_LSB +: FIELD_W];
            spd_f = ctrl_merged[SPD_LSB +: FIELD_W];
            ipm_f = ctrl_merged[IPM_LSB +: FIELD_W];
        end

        // Any code with the low bit set holds the Phy in reset, reserved
        // ones too, so only a write that clears that bit lets it go.
        // reset held while detect LSB is one
        state_next.reset_hold = |(det_f & DET_INIT);
        state_next.offline = (det_f == DET_OFFLINE);

        // A reserved speed code is never guessed at; it caps nothing.
        // speed cap, reserved codes leave it free
        state_next.gen1_only = (spd_f == SPD_GEN1);

        // Reserved power codes block no state.
        // power state gating
        case (ipm_f)
            IPM_NO_PARTIAL:
            begin
                state_next.partial_blk = 1'b1;
                state_next.slumber_blk = 1'b0;
            end
            IPM_NO_SLUMBER:
            begin
                state_next.partial_blk = 1'b0;
                state_next.slumber_blk = 1'b1;
            end
            IPM_NO_BOTH:
            begin
                state_next.partial_blk = 1'b1;
                state_next.slumber_blk = 1'b1;
            end
            default:
            begin
                state_next.partial_blk = 1'b0;
                state_next.slumber_blk = 1'b0;
            end
        endcase
    end

    // ============================================================
    // Registers
    // reset clears flags and control
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_reg.rdy_meta <= 1'b0;
            state_reg.rdy_sync <= 1'b0;
            state_reg.rdy_prev <= 1'b0;
            state_reg.link_lost <= 1'b0;
            state_reg.ack <= 1'b0;
            state_reg.rdat <= ZERO_WORD;
            state_reg.ctrl <= CTRL_RESET;
            state_reg.reset_hold <= 1'b0;
            state_reg.offline <= 1'b0;
            state_reg.gen1_only <= 1'b0;
            state_reg.partial_blk <= 1'b0;
            state_reg.slumber_blk <= 1'b0;
            state_reg.ctrl_upd <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // ============================================================
    // Outputs
    // Every output is a field of the state word, so none has a
    // combinational path from the bus or the event pins.
    assign WB_ACK_O = state_reg.ack;
    assign WB_DAT_O = state_reg.rdat;
    assign PHY_RESET_HOLD = state_reg.reset_hold;
    assign PHY_OFFLINE = state_reg.offline;
    assign SPEED_GEN1_ONLY = state_reg.gen1_only;
    assign PARTIAL_BLOCK = state_reg.partial_blk;
    assign SLUMBER_BLOCK = state_reg.slumber_blk;
    assign CTRL_UPDATE = state_reg.ctrl_upd;

endmodule
`default_nettype wire

// ### include/scr_pkg.sv
// Purpose: Shared constants for the serial interface error and control regs.
// Assumes: One 50 MHz clock; classic Wishbone slave with 32-bit data.
// Notes: Register index times four gives the byte address.
package scr_pkg;

    // ============================================================
    // Bus geometry
    localparam int DATA_W = 32;
    localparam int ADR_W = 6;
    localparam int SEL_W = 4;
    localparam int BYTE_W = 8;
    localparam int IDX_LSB = 2;
    localparam int IDX_W = 4;
    localparam logic [IDX_W-1:0] ERR_IDX = 4'h1;
    localparam logic [IDX_W-1:0] CTRL_IDX = 4'h2;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    // ============================================================
    // Error register bit positions
    localparam int ERR_RECOV_INTEG = 0;
    localparam int ERR_RECOV_COMM = 1;
    localparam int ERR_TRANSIENT = 8;
    localparam int ERR_PERSIST = 9;
    localparam int ERR_PROTOCOL = 10;
    localparam int ERR_INTERNAL = 11;
    localparam int DIAGNOSTIC_FIELD_READY_CHG = 16;
    localparam int DIAGNOSTIC_FIELD_PHY_INT = 17;
    localparam int DIAGNOSTIC_FIELD_WAKE = 18;
    localparam int DIAGNOSTIC_FIELD_DECODE = 19;
    localparam int DIAGNOSTIC_FIELD_DISPARITY = 20;
    localparam int DIAGNOSTIC_FIELD_CRC = 21;
    localparam int DIAGNOSTIC_FIELD_HANDSHAKE = 22;
    localparam int DIAGNOSTIC_FIELD_LINK_SEQ = 23;
    localparam int DIAGNOSTIC_FIELD_TRANSPORT = 24;
    localparam int DIAGNOSTIC_FIELD_UNKNOWN_FIS = 25;
    localparam logic [DATA_W-1:0] ERR_VALID_MASK = 32'h03FF_0F03;
    localparam logic [DATA_W-1:0] ERR_RESET = 32'h0000_0000;

    // ============================================================
    // Control register fields and encodings
    localparam int CTRL_W = 12;
    localparam int DET_LSB = 0;
    localparam int SPD_LSB = 4;
    localparam int IPM_LSB = 8;
    localparam int FIELD_W = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
    localparam logic [FIELD_W-1:0] DET_NONE = 4'h0;
    localparam logic [FIELD_W-1:0] DET_INIT = 4'h1;
    localparam logic [FIELD_W-1:0] DET_OFFLINE = 4'h4;
    localparam logic [FIELD_W-1:0] SPD_ANY = 4'h0;
    localparam logic [FIELD_W-1:0] SPD_GEN1 = 4'h1;
    localparam logic [FIELD_W-1:0] IPM_NO_PARTIAL = 4'h1;
    localparam logic [FIELD_W-1:0] IPM_NO_SLUMBER = 4'h2;
    localparam logic [FIELD_W-1:0] IPM_NO_BOTH = 4'h3;

endpackage

// ### include/err_evt_if.sv
// Purpose: Carries error events and clear masks to the sticky flag store.
// Assumes: Both ends on the same clock.
// Notes: Clear mask is live for one cycle per error register write.
`timescale 1ns/10ps
`default_nettype none
interface err_evt_if;
    import scr_pkg::*;
    logic [DATA_W-1:0] set_vec;
    logic [DATA_W-1:0] clr_mask;
    logic [DATA_W-1:0] flags;
    modport src
    (
        output set_vec,
        output clr_mask,
        input flags
    );
    modport sink
    (
        input set_vec,
        input clr_mask,
        output flags
    );
endinterface
`default_nettype wire

// ### src/error_flags.sv
// Purpose: Sticky error flag store with write-one-to-clear.
// Assumes: Events and clears are single-cycle, same-clock.
// Notes: Reserved positions are forced to zero.
`timescale 1ns/10ps
`default_nettype none
module error_flags
    import scr_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Event and clear carrier
    err_evt_if.sink evt
);

    typedef struct packed {
        logic [DATA_W-1:0] flags;
    } flag_state_t;

    flag_state_t state_reg;
    flag_state_t state_next;

    // ============================================================
    // Next state
    always_comb
    begin
        state_next = state_reg;
        // An event in the clearing cycle survives the clear.
        // set beats clear
        state_next.flags = ((state_reg.flags & ~evt.clr_mask) | evt.set_vec)
            & ERR_VALID_MASK;
    end

    // ============================================================
    // Registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg.flags <= ERR_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign evt.flags = state_reg.flags;

endmodule
`default_nettype wire

// ### testbench/serial_regs_assertions.sv
// Purpose: Port-level checks on the serial error and control registers.
// Assumes: One clock; reset is asynchronous and active low.
// Notes: Sees bus and control outputs only, so flag values are left to tb.
`timescale 1ns/10ps
`default_nettype none
module serial_regs_chk
    import scr_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Bus
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [ADR_W-1:0] WB_ADR_I,
    input wire logic [SEL_W-1:0] WB_SEL_I,
    input wire logic [DATA_W-1:0] WB_DAT_I,
    input wire logic [DATA_W-1:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Control outputs
    input wire logic PHY_RESET_HOLD,
    input wire logic PHY_OFFLINE,
    input wire logic SPEED_GEN1_ONLY,
    input wire logic PARTIAL_BLOCK,
    input wire logic SLUMBER_BLOCK,
    input wire logic CTRL_UPDATE
);
    logic req;
    logic ctrl_wr;
    logic [3:0] idx;
    assign req = WB_CYC_I && WB_STB_I;
    assign idx = WB_ADR_I[5:2];
    assign ctrl_wr = WB_ACK_O && req && WB_WE_I && idx == CTRL_IDX;

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    // ============================================================
    // Bus answers
    chk_ack_latency: assert property (req && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not acked one cycle after it was taken");
    chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held longer than one cycle");
    chk_ack_cause: assert property (WB_ACK_O |-> $past(req))
        else $error("ack without a request");
    chk_data_idle: assert property ((!WB_ACK_O || $past(WB_WE_I))
        |-> WB_DAT_O == ZERO_WORD)
        else $error("read data driven outside a read ack");
    chk_err_reserved: assert property (WB_ACK_O && $past(idx) == ERR_IDX
        |-> (WB_DAT_O & ~ERR_VALID_MASK) == ZERO_WORD)
        else $error("error register reserved bits read nonzero");
    chk_ctrl_reserved: assert property (WB_ACK_O
        && $past(idx) == CTRL_IDX |-> WB_DAT_O[31:12] == 20'h0_0000)
        else $error("control register reserved bits read nonzero");

    // ============================================================
    // Control effects
    chk_update_pulse: assert property (ctrl_wr
        |=> CTRL_UPDATE ##1 !CTRL_UPDATE)
        else $error("control write gave no single update pulse");
    chk_update_cause: assert property (CTRL_UPDATE |-> $past(ctrl_wr))
        else $error("update pulse without a control write");
    chk_outs_hold: assert property (!$stable({PHY_RESET_HOLD,
        PHY_OFFLINE, SPEED_GEN1_ONLY, PARTIAL_BLOCK, SLUMBER_BLOCK})
        |-> CTRL_UPDATE)
        else $error("control output moved without a control write");
    chk_offline_excl: assert property (PHY_OFFLINE |-> !PHY_RESET_HOLD)
        else $error("offline and reset hold raised together");
    chk_hold_follow: assert property (ctrl_wr && WB_SEL_I[0]
        |=> PHY_RESET_HOLD == $past(WB_DAT_I[DET_LSB]))
        else $error("reset hold does not follow the detect low bit");
    chk_gen1_follow: assert property (ctrl_wr && WB_SEL_I[0]
        |=> SPEED_GEN1_ONLY == ($past(WB_DAT_I[7:4]) == SPD_GEN1))
        else $error("speed cap does not follow the written speed code");
endmodule

bind serial_regs serial_regs_chk u_chk
(
    .CLK(CLK), .RST_B(RST_B), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_O(WB_DAT_O),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_ACK_O(WB_ACK_O), .PHY_RESET_HOLD(PHY_RESET_HOLD),
    .PHY_OFFLINE(PHY_OFFLINE), .SPEED_GEN1_ONLY(SPEED_GEN1_ONLY),
    .PARTIAL_BLOCK(PARTIAL_BLOCK), .SLUMBER_BLOCK(SLUMBER_BLOCK),
    .CTRL_UPDATE(CTRL_UPDATE)
);
`default_nettype wire

// ### testbench/tb_top.sv
// Purpose: Self-checking bench for the serial error and control registers.
// Assumes: Classic Wishbone; the bench never assumes the ack latency.
// Notes: Event inputs are gathered in one vector in port order.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import scr_pkg::*;
;
    logic clk;
    logic rst_b;
    logic cyc, stb, we, ack, ready;
    logic [ADR_W-1:0] adr;
    logic [SEL_W-1:0] sel;
    logic [DATA_W-1:0] dat_i, dat_o, q;
    logic [13:0] ev;
    logic [5:0] outs;
    logic [11:0] v;
    logic [4:0] x;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int i;
    int ebit [14] = '{DIAGNOSTIC_FIELD_PHY_INT, DIAGNOSTIC_FIELD_WAKE, DIAGNOSTIC_FIELD_DECODE, DIAGNOSTIC_FIELD_DISPARITY,
        DIAGNOSTIC_FIELD_CRC, DIAGNOSTIC_FIELD_HANDSHAKE, DIAGNOSTIC_FIELD_LINK_SEQ, DIAGNOSTIC_FIELD_UNKNOWN_FIS,
        DIAGNOSTIC_FIELD_TRANSPORT, ERR_PROTOCOL, ERR_PERSIST, ERR_INTERNAL,
        ERR_RECOV_INTEG, ERR_TRANSIENT};
    logic [11:0] ctab [8] = '{12'h001, 12'h005, 12'h004, 12'h010, 12'h100,
        12'h200, 12'h300, 12'h000};

    serial_regs u_dut
    (
        .CLK(clk), .RST_B(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .PHY_READY(ready),
        .PHY_INT_ERR(ev[0]), .COMWAKE_SEEN(ev[1]), .DECODE_ERR(ev[2]),
        .DISPARITY_ERR(ev[3]), .CRC_ERR(ev[4]), .HANDSHAKE_ERR(ev[5]),
        .LINK_SEQ_ERR(ev[6]), .UNKNOWN_FIS(ev[7]), .TRANSPORT_ERR(ev[8]),
        .PROTOCOL_ERR(ev[9]), .PERSIST_ERR(ev[10]), .INTERNAL_ERR(ev[11]),
        .RECOV_INTEGRITY(ev[12]), .TRANSIENT_ERR(ev[13]),
        .PHY_RESET_HOLD(outs[5]), .PHY_OFFLINE(outs[4]),
        .SPEED_GEN1_ONLY(outs[3]), .PARTIAL_BLOCK(outs[2]),
        .SLUMBER_BLOCK(outs[1]), .CTRL_UPDATE(outs[0])
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ============================================================
    // Bus and check tasks
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // An event in evv is raised so that it meets the write's own ack edge.
    task automatic wb(input logic w, input logic [3:0] idx,
        input logic [3:0] s, input logic [31:0] d, input logic [13:0] evv);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        dat_i <= d;
        do
        begin
            @(posedge clk);
            n++;
            if (ack !== 1'b1)
                ev <= evv;
        end
        while (ack !== 1'b1 && n < 20);
        q = dat_o;
        if (n >= 20)
            failures++;
        cyc <= 1'b0;
        stb <= 1'b0;
        ev <= '0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [3:0] idx);
        wb(1'b0, idx, 4'hF, ZERO_WORD, '0);
    endtask

    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        wb(1'b1, idx, 4'hF, d, '0);
    endtask

    task automatic pulse(input logic [13:0] p);
        ev <= p;
        @(posedge clk);
        ev <= '0;
        @(posedge clk);
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            failures++;
            stop_test();
        end
    end

    // ============================================================
    // Test sequence
    initial
    begin
        rst_b = 1'b0;
        {cyc, stb, we, ready} = 4'h0;
        adr = '0;
        sel = '0;
        dat_i = '0;
        ev = '0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(ERR_IDX);
        check("err reset", q, ERR_RESET);
        rd(CTRL_IDX);
        check("ctrl reset", q, ZERO_WORD);
        $display("test reset done");
        for (i = 0; i < 14; i++)
        begin
            pulse(14'h1 << i);
            wr(ERR_IDX, ~(32'h1 << ebit[i]));
            rd(ERR_IDX);
            check("flag", q, 32'h1 << ebit[i]);
            check("bit", {31'h0, q[ebit[i]]}, 32'h1);
            wr(ERR_IDX, 32'h1 << ebit[i]);
            rd(ERR_IDX);
            check("flag clear", q, ZERO_WORD);
        end
        ready <= 1'b1;
        repeat (8) @(posedge clk);
        rd(ERR_IDX);
        check("ready rise", q, 32'h0001_0000);
        wr(ERR_IDX, 32'h0001_0000);
        ready <= 1'b0;
        repeat (8) @(posedge clk);
        ready <= 1'b1;
        repeat (8) @(posedge clk);
        pulse(14'h3FFF);
        rd(ERR_IDX);
        check("all flags", q, ERR_VALID_MASK);
        wb(1'b1, ERR_IDX, 4'h1, 32'hFFFF_FFFF, '0);
        rd(ERR_IDX);
        check("lane clear", q, ERR_VALID_MASK & 32'hFFFF_FF00);
        wr(ERR_IDX, 32'hFFFF_FFFF);
        wb(1'b1, ERR_IDX, 4'hF, 32'h1 << ERR_PROTOCOL, 14'h1 << 9);
        rd(ERR_IDX);
        check("set over clear", q, 32'h1 << ERR_PROTOCOL);
        wr(ERR_IDX, 32'hFFFF_FFFF);
        $display("test error flags done");
        for (i = 0; i < 8; i++)
        begin
            v = ctab[i];
            wr(CTRL_IDX, 32'hFFFF_F000 | {20'h0_0000, v});
            x[4] = v[0];
            x[3] = v[3:0] == DET_OFFLINE;
            x[2] = v[7:4] == SPD_GEN1;
            x[1] = v[11:8] == IPM_NO_PARTIAL || v[11:8] == IPM_NO_BOTH;
            x[0] = v[11:8] == IPM_NO_SLUMBER || v[11:8] == IPM_NO_BOTH;
            check("ctrl outs", {27'h0, outs[5:1]}, {27'h0, x});
            rd(CTRL_IDX);
            check("ctrl read", q, {20'h0_0000, v});
        end
        wr(4'h3, 32'hFFFF_FFFF);
        rd(4'h3);
        check("unmapped", q, ZERO_WORD);
        rd(CTRL_IDX);
        check("ctrl kept", q, ZERO_WORD);
        $display("test control done");
        ready <= 1'b0;
        pulse(14'h1 << 10);
        wr(CTRL_IDX, 32'h0000_0311);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        check("outs in reset", {26'h0, outs}, ZERO_WORD);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(ERR_IDX);
        check("err after reset", q, ZERO_WORD);
        $display("test mid reset done");
        stop_test();
    end
endmodule
`default_nettype wire
